/* hdl/mcs_client_stream.sv */
// client side status outputs and receive stream path, with its small beat buffer
`timescale 1ns/1ps
// Overview of operation
// - status bit 32 marks stacked VLAN frame
// - status bits 31:16 carry full frame length
// - status bits 15:0 carry payload length
// - seven-bit error: bit2 length, bit1 oversize
// - receive beat is two 64-bit words
// - receive signals timed by the receive clock
// - receive clock trusted only after coding-layer ready
// - preamble output valid with start marker
// - receive strobe may gap inside frame
// - alignment marker cycles become idle cycles
// - start marks first byte, or preamble
// - end marks last payload byte, any lane
// - crc pass-through forwards FCS, end on it
// - status strobe only with meaningful status
// - empty count of unused low lanes at end
// - 40-bit status, bits 39:33 frame types

// small synchronous fifo of beats
module mcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_W = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];  // beat storage
  logic [AW:0] wr_ptr_ff;            // write pointer with wrap bit
  logic [AW:0] rd_ptr_ff;            // read pointer with wrap bit
  logic [AW:0] count;                // beats held
  logic push;
  logic pop;

  // honest flags straight from the pointers
  assign count = wr_ptr_ff - rd_ptr_ff;
  assign in_ready = (count != DEPTH_W);
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

  // storage write, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // pointer updates
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

// top: transmit status outputs and receive client stream
module mcs_client_stream
  import mcs_pkg::*;
#(
  parameter int FIFO_DEPTH = MCS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // configuration
  input wire logic preamble_passthru,
  input wire logic crc_passthru,
  // coding-layer ready, from outside this domain
  input wire logic rx_pcs_ready,
  // transmit engine status handover
  input wire logic tx_stat_in_valid,
  input wire mcs_tx_status_t tx_stat_in,
  input wire mcs_tx_error_t tx_err_in,
  // transmit status toward user logic
  output logic tx_frame_status_strobe,
  output logic [39:0] tx_status_word,
  output logic [6:0] tx_error_field,
  // receive engine beats, earliest byte in lane 0
  input wire logic eng_rx_valid,
  output logic eng_rx_ready,
  input wire logic eng_rx_align_marker,
  input wire logic eng_rx_sop,
  input wire logic eng_rx_last_data,
  input wire logic [3:0] eng_rx_empty_data,
  input wire logic eng_rx_last_fcs,
  input wire logic [3:0] eng_rx_empty_fcs,
  input wire logic [127:0] eng_rx_data,
  input wire logic [63:0] eng_rx_preamble,
  // receive stream toward user logic
  output logic rx_mac_clk,
  output logic rx_clk_stable,
  input wire logic client_rx_ready,
  output logic client_rx_strobe,
  output logic client_rx_sop,
  output logic client_rx_eop,
  output logic [3:0] client_rx_empty,
  output logic [127:0] client_rx_word,
  output logic [63:0] client_rx_preamble
);
  // receive frame tracking: one-hot states
  typedef enum logic [1:0] {
    ST_DATA = 2'b01,      // forwarding frame bytes
    ST_FCS_TAIL = 2'b10   // swallowing fcs beats after the payload end
  } mcs_rx_state_t;

  logic [1:0] ready_sync_ff;        // two-flop synchroniser for coding-layer ready
  logic [39:0] tx_status_ff;        // registered status word
  logic [6:0] tx_error_ff;          // registered error field
  logic tx_strobe_ff;               // registered status strobe
  mcs_rx_state_t state_ff;          // receive tracking state
  mcs_rx_state_t nxt_state;
  mcs_rx_beat_t wr_beat;            // beat going into the buffer
  mcs_rx_beat_t rd_beat;            // beat at the buffer head
  logic wr_en;                      // beat accepted into the buffer
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic drain;                      // user takes the head beat
  logic [127:0] swapped;            // byte-reversed engine data

  // the receive clock leaves on a pin; here the block's own clock plays that part
  assign rx_mac_clk = ref_clk;

  // ready comes from another layer, so it is synchronised before use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_sync_ff <= MCS_SYNC_RESET;
    end else begin
      ready_sync_ff <= {ready_sync_ff[0], rx_pcs_ready};
    end
  end
  assign rx_clk_stable = ready_sync_ff[1];

  // transmit status: one register stage, strobe and fields move together
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_strobe_ff <= 1'b0;
      tx_status_ff <= MCS_TXS_RESET;
      tx_error_ff <= MCS_TXE_RESET;
    end else begin
      tx_strobe_ff <= tx_stat_in_valid;
      if (tx_stat_in_valid) begin
        // struct order lays out types, stacked tag and lengths
        tx_status_ff <= tx_stat_in;
        // reserved bits held at zero
        tx_error_ff <= MCS_TXE_RESET;
        tx_error_ff[MCS_TXE_PLEN_BIT] <= tx_err_in.payload_len_err;
        tx_error_ff[MCS_TXE_OVERSIZE_BIT] <= tx_err_in.oversize;
      end
    end
  end
  assign tx_frame_status_strobe = tx_strobe_ff;
  assign tx_status_word = tx_status_ff;
  assign tx_error_field = tx_error_ff;

  // byte reversal: engine lane 0 lands in bits 127:120
  always_comb begin
    swapped = '0;
    for (int i = 0; i < MCS_BYTES; i++) begin
      swapped[8*(MCS_BYTES-1-i) +: 8] = eng_rx_data[8*i +: 8];
    end
  end

  // fcs tail tracking: without pass-through the fcs beats are dropped
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_DATA: begin
        // payload ends but fcs continues in a later beat
        if (wr_en && !crc_passthru && eng_rx_last_data && !eng_rx_last_fcs) begin
          nxt_state = ST_FCS_TAIL;
        end
      end
      ST_FCS_TAIL: begin
        // engine beat carrying the last fcs byte closes the tail
        if (eng_rx_valid && !eng_rx_align_marker && eng_rx_last_fcs) begin
          nxt_state = ST_DATA;
        end
      end
      default: begin
        nxt_state = ST_DATA;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_DATA;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // marker cycles never enter the buffer, so they show as idle cycles
  assign wr_en = eng_rx_valid && !eng_rx_align_marker && fifo_in_ready
    && (state_ff == ST_DATA);
  // tail beats are swallowed at once; the engine only stalls on a full buffer
  assign eng_rx_ready = fifo_in_ready || (state_ff == ST_FCS_TAIL) || eng_rx_align_marker;

  // assemble the beat for the buffer
  always_comb begin
    wr_beat = '0;
    wr_beat.data = swapped;
    // start flags first frame byte, in pass-through the preamble shares it
    wr_beat.sop = eng_rx_sop;
    if (crc_passthru) begin
      // end moves to the last fcs byte
      wr_beat.eop = eng_rx_last_fcs;
      wr_beat.empty = eng_rx_last_fcs ? eng_rx_empty_fcs : 4'h0;
    end else begin
      // end sits on the last payload byte, any lane
      wr_beat.eop = eng_rx_last_data;
      wr_beat.empty = eng_rx_last_data ? eng_rx_empty_data : 4'h0;
    end
    // preamble rides with the start beat only
    if (preamble_passthru && eng_rx_sop) begin
      wr_beat.preamble = eng_rx_preamble;
    end
  end

  // four-beat buffer; its fill ready stalls the engine
  mcs_fifo #(
    .WIDTH($bits(mcs_rx_beat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(wr_en),
    .in_ready(fifo_in_ready),
    .in_data(wr_beat),
    .out_valid(fifo_out_valid),
    .out_ready(drain),
    .out_data(rd_beat)
  );

  // strobe drops whenever the buffer runs dry, so frames may show gaps
  assign client_rx_strobe = fifo_out_valid && rx_clk_stable;
  assign drain = client_rx_strobe && client_rx_ready;
  assign client_rx_sop = rd_beat.sop;
  assign client_rx_eop = rd_beat.eop;
  assign client_rx_empty = rd_beat.empty;
  assign client_rx_word = rd_beat.data;
  assign client_rx_preamble = rd_beat.preamble;

  // checks next to the logic they guard
  property p_svlan;
    @(posedge ref_clk) disable iff (!rst_n)
    tx_stat_in_valid |=> tx_status_word[MCS_TXS_SVLAN_BIT] == $past(tx_stat_in.stacked_vlan);
  endproperty
  a_svlan: assert property (p_svlan) else $error("stacked vlan bit wrong");

  property p_flen;
    @(posedge ref_clk) disable iff (!rst_n)
    tx_stat_in_valid |=> tx_status_word[MCS_TXS_FLEN_HI:MCS_TXS_FLEN_LO]
      == $past(tx_stat_in.frame_len);
  endproperty
  a_flen: assert property (p_flen) else $error("frame length field wrong");

  property p_plen;
    @(posedge ref_clk) disable iff (!rst_n)
    tx_stat_in_valid |=> tx_status_word[MCS_TXS_PLEN_HI:MCS_TXS_PLEN_LO]
      == $past(tx_stat_in.payload_len);
  endproperty
  a_plen: assert property (p_plen) else $error("payload length field wrong");

  property p_err;
    @(posedge ref_clk) disable iff (!rst_n)
    tx_stat_in_valid |=> tx_error_field == {4'h0, $past(tx_err_in.payload_len_err),
      $past(tx_err_in.oversize), 1'b0};
  endproperty
  a_err: assert property (p_err) else $error("error field wrong");

  property p_types;
    @(posedge ref_clk) disable iff (!rst_n)
    tx_stat_in_valid |=> tx_status_word[MCS_TXS_PFC_BIT:MCS_TXS_VLAN_BIT]
      == $past(tx_stat_in[MCS_TXS_PFC_BIT:MCS_TXS_VLAN_BIT]);
  endproperty
  a_types: assert property (p_types) else $error("frame type bits wrong");

  property p_strobe;
    @(posedge ref_clk) disable iff (!rst_n)
    tx_frame_status_strobe == $past(tx_stat_in_valid);
  endproperty
  a_strobe: assert property (p_strobe) else $error("status strobe misplaced");

  property p_marker;
    @(posedge ref_clk) disable iff (!rst_n)
    eng_rx_valid && eng_rx_align_marker && !fifo_out_valid
      |-> eng_rx_ready ##1 !fifo_out_valid;
  endproperty
  a_marker: assert property (p_marker) else $error("marker cycle buffered");

  property p_ready_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    !rx_pcs_ready [*2] |=> !client_rx_strobe;
  endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("strobe before ready");

  property p_swap;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_en |-> wr_beat.data[127:120] == eng_rx_data[7:0]
      && wr_beat.data[7:0] == eng_rx_data[127:120];
  endproperty
  a_swap: assert property (p_swap) else $error("byte order not reversed");

  property p_empty;
    @(posedge ref_clk) disable iff (!rst_n)
    client_rx_strobe && !client_rx_eop |-> client_rx_empty == 4'h0;
  endproperty
  a_empty: assert property (p_empty) else $error("empty count outside end beat");

  property p_crc_end;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_en && crc_passthru |-> wr_beat.eop == eng_rx_last_fcs;
  endproperty
  a_crc_end: assert property (p_crc_end) else $error("end not on fcs");

  property p_preamble;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_en && preamble_passthru && eng_rx_sop |-> wr_beat.preamble == eng_rx_preamble;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble not with start");

  property p_tail_drop;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_en && !crc_passthru && eng_rx_last_data && !eng_rx_last_fcs |=> !wr_en;
  endproperty
  a_tail_drop: assert property (p_tail_drop) else $error("fcs beat forwarded");
endmodule

/* hdl/mcs_pkg.sv */
// shared constants, types and field layouts for the client stream and status block
package mcs_pkg;
  // receive datapath geometry
  localparam int MCS_WORD_BITS = 64;                     // one half of the receive beat
  localparam int MCS_WORDS = 2;                          // words per beat
  localparam int MCS_DATA_BITS = MCS_WORD_BITS * MCS_WORDS;
  localparam int MCS_BYTES = MCS_DATA_BITS / 8;
  localparam int MCS_PRE_BITS = 64;                      // preamble width
  localparam int MCS_FIFO_DEPTH = 4;                     // receive buffer depth in beats
  // receive clock figure, in kHz as printed (390.625 MHz)
  localparam int MCS_RX_CLK_KHZ = 390625;
  // transmit status word layout
  localparam int MCS_TXS_BITS = 40;
  localparam int MCS_TXS_PFC_BIT = 39;
  localparam int MCS_TXS_VLAN_BIT = 33;
  localparam int MCS_TXS_SVLAN_BIT = 32;
  localparam int MCS_TXS_FLEN_HI = 31;
  localparam int MCS_TXS_FLEN_LO = 16;
  localparam int MCS_TXS_PLEN_HI = 15;
  localparam int MCS_TXS_PLEN_LO = 0;
  // transmit error field layout
  localparam int MCS_TXE_BITS = 7;
  localparam int MCS_TXE_PLEN_BIT = 2;
  localparam int MCS_TXE_OVERSIZE_BIT = 1;
  // values after reset
  localparam logic [39:0] MCS_TXS_RESET = 40'h00_0000_0000;
  localparam logic [6:0] MCS_TXE_RESET = 7'h00;
  localparam logic [1:0] MCS_SYNC_RESET = 2'h0;

  // frame facts handed over by the transmit engine, ordered as the status word
  typedef struct packed {
    logic pfc;
    logic unicast;
    logic multicast;
    logic broadcast;
    logic pause;
    logic control;
    logic vlan;
    logic stacked_vlan;
    logic [15:0] frame_len;
    logic [15:0] payload_len;
  } mcs_tx_status_t;

  // transmit error facts
  typedef struct packed {
    logic payload_len_err;
    logic oversize;
  } mcs_tx_error_t;

  // one buffered receive beat
  typedef struct packed {
    logic sop;
    logic eop;
    logic [3:0] empty;
    logic [127:0] data;
    logic [63:0] preamble;
  } mcs_rx_beat_t;
endpackage

/* tb/mcs_client_stream_tb_top.sv */
// self-checking bench for the client status and receive stream block
`timescale 1ns/1ps
module mcs_client_stream_tb_top;
  import mcs_pkg::*;
  // clock, reset, configuration
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic preamble_passthru = 1'b0;
  logic crc_passthru = 1'b0;
  logic rx_pcs_ready = 1'b0;
  // transmit status handover
  logic tx_stat_in_valid = 1'b0;
  mcs_tx_status_t tx_stat_in = '0;
  mcs_tx_error_t tx_err_in = '0;
  logic tx_frame_status_strobe;
  logic [39:0] tx_status_word;
  logic [6:0] tx_error_field;
  // engine side beats
  logic eng_rx_valid = 1'b0, eng_rx_align_marker = 1'b0, eng_rx_sop = 1'b0;
  logic eng_rx_last_data = 1'b0, eng_rx_last_fcs = 1'b0, eng_rx_ready;
  logic [3:0] eng_rx_empty_data = 4'h0, eng_rx_empty_fcs = 4'h0;
  logic [127:0] eng_rx_data = '0;
  logic [63:0] eng_rx_preamble = '0;
  // user side stream
  logic rx_mac_clk, rx_clk_stable, client_rx_ready, client_rx_strobe;
  logic client_rx_sop, client_rx_eop;
  logic [3:0] client_rx_empty;
  logic [127:0] client_rx_word;
  logic [63:0] client_rx_preamble;
  logic [1:0] stall_mode = 2'h0;
  // bookkeeping
  int n_fail = 0;
  int compares = 0;
  mcs_rx_beat_t exp_q[$]; // beats the user should see
  logic in_tail = 1'b0; // swallowing fcs beats

  always #2 ref_clk = ~ref_clk;

  mcs_client_stream #(.FIFO_DEPTH(4)) mcs_client_stream_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .preamble_passthru(preamble_passthru),
    .crc_passthru(crc_passthru), .rx_pcs_ready(rx_pcs_ready),
    .tx_stat_in_valid(tx_stat_in_valid), .tx_stat_in(tx_stat_in), .tx_err_in(tx_err_in),
    .tx_frame_status_strobe(tx_frame_status_strobe), .tx_status_word(tx_status_word),
    .tx_error_field(tx_error_field), .eng_rx_valid(eng_rx_valid), .eng_rx_ready(eng_rx_ready),
    .eng_rx_align_marker(eng_rx_align_marker), .eng_rx_sop(eng_rx_sop),
    .eng_rx_last_data(eng_rx_last_data), .eng_rx_empty_data(eng_rx_empty_data),
    .eng_rx_last_fcs(eng_rx_last_fcs), .eng_rx_empty_fcs(eng_rx_empty_fcs),
    .eng_rx_data(eng_rx_data), .eng_rx_preamble(eng_rx_preamble), .rx_mac_clk(rx_mac_clk),
    .rx_clk_stable(rx_clk_stable), .client_rx_ready(client_rx_ready),
    .client_rx_strobe(client_rx_strobe), .client_rx_sop(client_rx_sop),
    .client_rx_eop(client_rx_eop), .client_rx_empty(client_rx_empty),
    .client_rx_word(client_rx_word), .client_rx_preamble(client_rx_preamble));

  mcs_user_sink mcs_user_sink_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .stall_mode(stall_mode),
    .client_rx_strobe(client_rx_strobe), .client_rx_ready(client_rx_ready),
    .client_rx_sop(client_rx_sop), .client_rx_eop(client_rx_eop),
    .client_rx_empty(client_rx_empty), .client_rx_word(client_rx_word),
    .client_rx_preamble(client_rx_preamble));

  // one comparison, four-state exact
  task automatic check(input logic [199:0] seen, input logic [199:0] want);
    compares++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // earliest byte moves from lane 0 to the top lane
  function automatic logic [127:0] rev_bytes(input logic [127:0] d);
    for (int i = 0; i < 16; i++) begin
      rev_bytes[127-8*i -: 8] = d[8*i +: 8];
    end
  endfunction

  // expected user beat for one accepted engine beat
  function automatic mcs_rx_beat_t want_beat(input logic sop, ld, lf, input logic [3:0] ed, ef,
                                             input logic [127:0] d, input logic [63:0] p);
    logic eop;
    eop = crc_passthru ? lf : ld;
    return mcs_rx_beat_t'{sop, eop, eop ? (crc_passthru ? ef : ed) : 4'h0, rev_bytes(d),
                          (preamble_passthru && sop) ? p : 64'h0};
  endfunction

  // present one beat from the falling edge, hold it until taken
  task automatic send_beat(input logic mk, sop, ld, lf, input logic [3:0] ed, ef);
    int n;
    n = 0;
    @(negedge ref_clk);
    eng_rx_valid = 1'b1;
    eng_rx_align_marker = mk;
    eng_rx_sop = sop;
    eng_rx_last_data = ld;
    eng_rx_last_fcs = lf;
    eng_rx_empty_data = ed;
    eng_rx_empty_fcs = ef;
    eng_rx_data = {$urandom, $urandom, $urandom, $urandom};
    eng_rx_preamble = {$urandom, $urandom};
    #1;
    while (!eng_rx_ready && n < 300) begin
      @(negedge ref_clk);
      #1;
      n++;
    end
    if (n >= 300) n_fail++;
    @(posedge ref_clk);
    if (!mk && !in_tail) begin
      exp_q.push_back(want_beat(sop, ld, lf, ed, ef, eng_rx_data, eng_rx_preamble));
      in_tail = !crc_passthru && ld && !lf;
    end else if (!mk && lf) begin
      in_tail = 1'b0;
    end
  endtask

  // one frame, optional fcs tail beat, optional marker before beat mk
  task automatic frame(input int nb, input bit tail, input int mk);
    logic [3:0] ed;
    ed = tail ? 4'($urandom) : 4'($urandom_range(15, 4));
    for (int i = 0; i < nb; i++) begin
      if (i == mk) send_beat(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
      send_beat(1'b0, i == 0, i == nb - 1, (i == nb - 1) && !tail, ed, ed - 4'h4);
    end
    if (tail) send_beat(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'($urandom));
    @(negedge ref_clk);
    eng_rx_valid = 1'b0;
  endtask

  // wait for the user side to catch up, then compare beat by beat
  task automatic drain_compare(input string name);
    int n;
    n = 0;
    while (mcs_user_sink_i.got_q.size() < exp_q.size() && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    check(mcs_user_sink_i.got_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      if (i < mcs_user_sink_i.got_q.size()) begin
        check(mcs_user_sink_i.got_q[i], exp_q[i]);
      end
    end
    exp_q.delete();
    mcs_user_sink_i.got_q.delete();
    in_tail = 1'b0;
    $display("test %s done", name);
  endtask

  // status word and error field follow each taken status, back to back first
  task automatic tx_status_test();
    logic v;
    logic pv;
    logic [39:0] w;
    logic [6:0] e;
    pv = 1'b0;
    w = MCS_TXS_RESET;
    e = MCS_TXE_RESET;
    for (int i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      check(tx_frame_status_strobe, pv);
      check(tx_status_word, w);
      check(tx_error_field, e);
      v = (i < 8) ? 1'b1 : 1'($urandom_range(1));
      tx_stat_in = mcs_tx_status_t'({$urandom, 8'($urandom)});
      tx_err_in = mcs_tx_error_t'(2'($urandom));
      tx_stat_in_valid = v;
      if (v) begin
        // expected word placed field by field from the layout constants
        w[MCS_TXS_PFC_BIT:MCS_TXS_VLAN_BIT] = {tx_stat_in.pfc, tx_stat_in.unicast,
          tx_stat_in.multicast, tx_stat_in.broadcast, tx_stat_in.pause, tx_stat_in.control,
          tx_stat_in.vlan};
        w[MCS_TXS_SVLAN_BIT] = tx_stat_in.stacked_vlan;
        w[MCS_TXS_FLEN_HI:MCS_TXS_FLEN_LO] = tx_stat_in.frame_len;
        w[MCS_TXS_PLEN_HI:MCS_TXS_PLEN_LO] = tx_stat_in.payload_len;
        e = MCS_TXE_RESET;
        e[MCS_TXE_PLEN_BIT] = tx_err_in.payload_len_err;
        e[MCS_TXE_OVERSIZE_BIT] = tx_err_in.oversize;
      end
      pv = v;
    end
    @(negedge ref_clk);
    check(tx_frame_status_strobe, pv);
    check(tx_status_word, w);
    check(tx_error_field, e);
    tx_stat_in_valid = 1'b0;
    $display("test tx_status done");
  endtask

  // closing verdict, single exit point
  task automatic close_out();
    $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog: whole run is well under this span
  initial begin
    #(40000 * 4);
    n_fail++;
    close_out();
  end

  // main sequence
  initial begin
    void'($urandom(32'h5795ef50));
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    tx_status_test();
    // beats buffer but stay hidden until the coding layer is ready
    fork frame(2, 1'b0, 1); join_none
    repeat (8) @(negedge ref_clk);
    #1;
    check(client_rx_strobe, 1'b0);
    check(rx_mac_clk, 1'b0);
    rx_pcs_ready = 1'b1;
    @(negedge ref_clk);
    check(rx_clk_stable, 1'b0);
    @(negedge ref_clk);
    check(rx_clk_stable, 1'b1);
    wait fork;
    drain_compare("clk_stable");
    // every pass-through combination, with random stalls and markers
    stall_mode = 2'h1;
    for (int m = 0; m < 4; m++) begin
      preamble_passthru = m[0];
      crc_passthru = m[1];
      repeat (4) frame(1 + $urandom_range(3), 1'($urandom_range(1)), $urandom_range(4));
      drain_compare("passthru_mode");
    end
    // buffer fills and refuses while the user holds off
    stall_mode = 2'h2;
    fork frame(6, 1'b0, 9); join_none
    repeat (12) @(negedge ref_clk);
    #1;
    check(eng_rx_ready, 1'b0);
    check(client_rx_strobe, 1'b1);
    stall_mode = 2'h1;
    wait fork;
    drain_compare("buffer_full");
    close_out();
  end
endmodule

/* tb/mcs_user_sink.sv */
// user-side sink model: takes receive beats, stalls on command
`timescale 1ns/1ps
module mcs_user_sink
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // stall control: 0 prompt, 1 random, 2 hold off
  input wire logic [1:0] stall_mode,
  // receive stream from the block
  input wire logic client_rx_strobe,
  output logic client_rx_ready,
  input wire logic client_rx_sop,
  input wire logic client_rx_eop,
  input wire logic [3:0] client_rx_empty,
  input wire logic [127:0] client_rx_word,
  input wire logic [63:0] client_rx_preamble
);
  mcs_rx_beat_t got_q[$]; // beats taken, oldest first

  // ready moves after the falling edge, never on the sampling edge
  always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      client_rx_ready <= 1'b0;
    end else if (stall_mode == 2'h2) begin
      client_rx_ready <= 1'b0;
    end else if (stall_mode == 2'h1) begin
      client_rx_ready <= 1'($urandom_range(1));
    end else begin
      client_rx_ready <= 1'b1;
    end
  end

  // take a beat only where the strobe qualifies it; gaps are simply waited out
  always @(posedge ref_clk) begin
    if (rst_n && client_rx_strobe && client_rx_ready) begin
      // word kept as seen, msb lane first, the order user logic also sends in
      got_q.push_back(mcs_rx_beat_t'{client_rx_sop, client_rx_eop, client_rx_empty,
                                     client_rx_word, client_rx_preamble});
    end
  end
endmodule
